// *** rtl/clkgen_select_prog.sv ***
// Purpose: select latches, mode choice and serial divider loader of a dual clock synthesizer
// Assumes: select pins are asynchronous to clk_sys; strobe and data held >= 3 clk_sys cycles
// Notes:   analog loop, oscillator and output drivers sit outside; this block hands them
//          the divider settings and driver controls
// Operation
// - low pointer-reset: pin0 is select bit0
// - low pointer-reset: pin1 is select bit1
// - strobe rising edge shifts one bit
// - low pointer-reset: select latch transparent
// - high pointer-reset: select latch holds
// - pointer-reset rising edge zeroes pointer
// - output equals reference times N/(M*P)
// - 7-bit M and N, P 1/2/4/8
// - divider value 0 acts as 1
// - internal mode uses mask presets
// - eight pixel presets, one memory preset
// - mode bit zero enables programmed mode
// - pixel programmed only on code 010, high
// - preset of code 010 then unavailable; code still selects it while pointer-reset is low
// - memory programmed mode ignores select pins
// - reset selects internal mode for both
// - per-generator tristate and oscillator off
// - twentieth bit loads word, zeroes pointer
// - bit0 one pixel, zero memory
// - tristate, oscillator off, mode, reset values
// - post, N and M field positions
`timescale 1ns/1ps
`include "clkgen_consts.svh"

module clkgen_select_prog #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input  wire  logic                     clk_sys,
    input  wire  logic                     nrst,
    input  wire  logic                     clk_en,
    // controller pins
    input  wire  logic                     select0_data,
    input  wire  logic                     select1_strobe,
    input  wire  logic                     select2,
    input  wire  logic                     latch_ptr_reset,
    // pixel generator settings
    output clkgen_pkg::div_type            pixel_m,
    output clkgen_pkg::div_type            pixel_n,
    output clkgen_pkg::post_val_type       pixel_p,
    output logic                           pixel_programmed,
    output logic                           pixel_out_en,
    output logic                           pixel_vco_en,
    output logic                           pixel_force_high,
    output logic [31:0]                    pixel_freq_hz,
    // memory generator settings
    output clkgen_pkg::div_type            memory_m,
    output clkgen_pkg::div_type            memory_n,
    output clkgen_pkg::post_val_type       memory_p,
    output logic                           memory_programmed,
    output logic                           memory_out_en,
    output logic                           memory_vco_en,
    output logic                           memory_force_high,
    output logic [31:0]                    memory_freq_hz,
    // axi4-lite slave
    input  wire  logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire  logic                     s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire  logic [31:0]              s_axi_wdata,
    input  wire  logic [3:0]               s_axi_wstrb,
    input  wire  logic                     s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire  logic                     s_axi_bready,
    input  wire  logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire  logic                     s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire  logic                     s_axi_rready
);
    import clkgen_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    // zero divides by one
    function automatic div_type div_eff(input div_type v);
        div_eff = (v == 7'h00) ? 7'h01 : v;
    endfunction : div_eff

    function automatic post_val_type post_val(input post_code_type c);
        post_val = 4'h1 << c;
    endfunction : post_val

    function automatic logic [15:0] pix_preset(input freq_sel_type s);
        case (s)
            3'h0:    pix_preset = `PIX_PRESET_0;
            3'h1:    pix_preset = `PIX_PRESET_1;
            3'h2:    pix_preset = `PIX_PRESET_2;
            3'h3:    pix_preset = `PIX_PRESET_3;
            3'h4:    pix_preset = `PIX_PRESET_4;
            3'h5:    pix_preset = `PIX_PRESET_5;
            3'h6:    pix_preset = `PIX_PRESET_6;
            3'h7:    pix_preset = `PIX_PRESET_7;
            default: pix_preset = `PIX_PRESET_0;
        endcase
    endfunction : pix_preset

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [3:0]    sync1_q;
    logic [3:0]    sync2_q;
    logic          lpr_prev_q;
    logic          strobe_prev_q;
    wire           data_s = sync2_q[0];
    wire           sel1_s = sync2_q[1];
    wire           sel2_s = sync2_q[2];
    wire           lpr_s  = sync2_q[3];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= {latch_ptr_reset, select2, select1_strobe, select0_data};
            sync2_q <= sync1_q;
        end
    end

    // pins act as data and strobe only while latch is high
    wire           strobe_lvl = lpr_s & sel1_s;
    wire           lpr_rise   = lpr_s & ~lpr_prev_q;
    wire           strobe_rise = strobe_lvl & ~strobe_prev_q & ~lpr_rise;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lpr_prev_q    <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else if (clk_en) begin
            lpr_prev_q    <= lpr_s;
            strobe_prev_q <= strobe_lvl;
        end
    end

    // ****************************************************************
    // frequency select latch
    // ****************************************************************
    freq_sel_type  fs_q;

    // transparent while low, holds while high
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fs_q <= 3'h0;
        end else if (clk_en && !lpr_s) begin
            fs_q <= {sel2_s, sel1_s, data_s};
        end
    end

    // ****************************************************************
    // serial loader
    // ****************************************************************
    logic [18:0]   shift_q;
    bit_ptr_type   ptr_q;
    wire           word_done = strobe_rise & (ptr_q == `SW_LAST_BIT);
    prog_word_type load_word;
    assign load_word = {data_s, shift_q};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_q <= 19'h0_0000;
            ptr_q   <= 5'h00;
        end else if (clk_en) begin
            if (lpr_rise) begin
                ptr_q <= 5'h00;
            end else if (word_done) begin
                ptr_q <= 5'h00;
            end else if (strobe_rise) begin
                shift_q[ptr_q] <= data_s;
                ptr_q          <= ptr_q + 5'h01;
            end
        end
    end

    // ****************************************************************
    // generator settings, index 1 pixel, 0 memory
    // ****************************************************************
    logic          tri_q  [2];
    logic          off_q  [2];
    logic          int_q  [2];
    post_code_type post_q [2];
    div_type       n_q    [2];
    div_type       m_q    [2];
    logic          prog_w [2];
    logic [15:0]   pre_w  [2];
    div_type       m_sel  [2];
    div_type       n_sel  [2];
    post_val_type  p_sel  [2];
    logic [63:0]   num_w  [2];
    logic [10:0]   den_w  [2];
    div_type       m_out_q[2];
    div_type       n_out_q[2];
    post_val_type  p_out_q[2];
    logic          prg_out_q[2];
    logic          oe_q   [2];
    logic          ven_q  [2];
    logic          high_q [2];
    logic [31:0]   freq_q [2];
    logic [31:0]   ref_hz_q;

    for (genvar g = 0; g < 2; g++) begin : gen_unit
        wire hit = word_done & (load_word[`SW_ADDR_BIT] == 1'(g));

        always_ff @(posedge clk_sys or negedge nrst) begin
            // internal mode, drivers and oscillators on
            if (!nrst) begin
                tri_q[g]  <= 1'b0;
                off_q[g]  <= 1'b0;
                int_q[g]  <= 1'b1;
                post_q[g] <= `RST_POST;
                n_q[g]    <= `RST_DIV;
                m_q[g]    <= `RST_DIV;
            end else if (clk_en && hit) begin
                tri_q[g]  <= load_word[`SW_TRISTATE_BIT];
                off_q[g]  <= load_word[`SW_VCO_OFF_BIT];
                int_q[g]  <= load_word[`SW_MODE_BIT];
                post_q[g] <= load_word[`SW_POST_LSB +: 2];
                n_q[g]    <= load_word[`SW_N_LSB +: 7];
                m_q[g]    <= load_word[`SW_M_LSB +: 7];
            end
        end

        if (g == 1) begin : gen_pix
            assign prog_w[g] = ~int_q[g] & lpr_s & (fs_q == `PROG_SELECT_CODE);
            assign pre_w[g]  = pix_preset(fs_q);
        end else begin : gen_mem
            assign prog_w[g] = ~int_q[g];
            assign pre_w[g]  = `MEM_PRESET;
        end
        assign m_sel[g] = div_eff(prog_w[g] ? m_q[g] : pre_w[g][15:9]);
        assign n_sel[g] = div_eff(prog_w[g] ? n_q[g] : pre_w[g][8:2]);
        assign p_sel[g] = post_val(prog_w[g] ? post_q[g] : pre_w[g][1:0]);
        // reference times N over M times P
        assign num_w[g] = {32'h0000_0000, ref_hz_q} * {57'h0, n_sel[g]};
        assign den_w[g] = {4'h0, m_sel[g]} * {7'h00, p_sel[g]};

        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                m_out_q[g]   <= 7'h01;
                n_out_q[g]   <= 7'h01;
                p_out_q[g]   <= 4'h1;
                prg_out_q[g] <= 1'b0;
                oe_q[g]      <= 1'b1;
                ven_q[g]     <= 1'b1;
                high_q[g]    <= 1'b0;
                freq_q[g]    <= 32'h0000_0000;
            end else if (clk_en) begin
                m_out_q[g]   <= m_sel[g];
                n_out_q[g]   <= n_sel[g];
                p_out_q[g]   <= p_sel[g];
                prg_out_q[g] <= prog_w[g];
                oe_q[g]      <= ~tri_q[g];
                ven_q[g]     <= ~off_q[g];
                high_q[g]    <= off_q[g] & ~tri_q[g];
                freq_q[g]    <= 32'(num_w[g] / {53'h0, den_w[g]});
            end
        end
    end

    assign pixel_m           = m_out_q[1];
    assign pixel_n           = n_out_q[1];
    assign pixel_p           = p_out_q[1];
    assign pixel_programmed  = prg_out_q[1];
    assign pixel_out_en      = oe_q[1];
    assign pixel_vco_en      = ven_q[1];
    assign pixel_force_high  = high_q[1];
    assign pixel_freq_hz     = freq_q[1];
    assign memory_m          = m_out_q[0];
    assign memory_n          = n_out_q[0];
    assign memory_p          = p_out_q[0];
    assign memory_programmed = prg_out_q[0];
    assign memory_out_en     = oe_q[0];
    assign memory_vco_en     = ven_q[0];
    assign memory_force_high = high_q[0];
    assign memory_freq_hz    = freq_q[0];

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [31:0]       rd_mux;
    logic              rd_hit;

    assign s_axi_awready = clk_en & ~aw_have_q;
    assign s_axi_wready  = clk_en & ~w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = clk_en & ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    wire ref_wr   = do_write & (awaddr_q[11:0] == `OFS_REF_HZ);
    wire ar_take  = s_axi_arvalid & s_axi_arready;

    function automatic logic [31:0] gen_status(input int g);
        gen_status = {12'h000, off_q[g], tri_q[g], int_q[g], prg_out_q[g],
                      post_q[g], n_out_q[g], m_out_q[g]};
    endfunction : gen_status

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr[11:0])
            `OFS_REF_HZ:        rd_mux = ref_hz_q;
            `OFS_PIXEL_STATUS:  rd_mux = gen_status(1);
            `OFS_MEMORY_STATUS: rd_mux = gen_status(0);
            `OFS_PIXEL_FREQ:    rd_mux = freq_q[1];
            `OFS_MEMORY_FREQ:   rd_mux = freq_q[0];
            `OFS_SERIAL_STATUS: rd_mux = {23'h00_0000, lpr_s, fs_q, ptr_q};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            // status words are read-only: writes to them are ignored with okay
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (awaddr_q[11:0] <= `OFS_SERIAL_STATUS &&
                              awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    for (genvar b = 0; b < 4; b++) begin : gen_ref_byte
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                ref_hz_q[b*8 +: 8] <= 8'(`RST_REF_HZ >> (b*8));
            end else if (clk_en && ref_wr && wstrb_q[b]) begin
                ref_hz_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= 2'h0;
            rdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_hit ? 2'h0 : 2'h2;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    ptr_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && lpr_rise |=> ptr_q == 5'h00)
        else $error("pointer not zeroed after pointer reset edge");

    shift_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && strobe_rise && !word_done |=>
        ptr_q == $past(ptr_q) + 5'h01 && shift_q[$past(ptr_q)] == $past(data_s))
        else $error("strobe edge did not shift bit at pointer");

    first_bit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && strobe_rise && ptr_q == 5'h00 |=> shift_q[0] == $past(data_s))
        else $error("first bit after pointer reset missed bit 0");

    word_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && word_done && load_word[0] |=>
        ptr_q == 5'h00 && n_q[1] == $past(load_word[12:6]) && m_q[1] == $past(load_word[19:13]))
        else $error("pixel word not loaded or pointer not rewound");

    other_kept_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && word_done && !load_word[0] |=>
        $stable(n_q[1]) && $stable(m_q[1]) && $stable(int_q[1]) && m_q[0] == $past(load_word[19:13]))
        else $error("memory load disturbed pixel settings");

    fs_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        lpr_s |=> $stable(fs_q))
        else $error("select latch moved while closed");

    fs_track_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && !lpr_s |=> fs_q == $past({sel2_s, sel1_s, data_s}))
        else $error("select latch not transparent");

    pix_source_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en |=> pixel_programmed ==
        $past(!int_q[1] && lpr_s && fs_q == `PROG_SELECT_CODE))
        else $error("pixel divider source wrong");

    mem_source_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en && !int_q[0] |=> memory_programmed && memory_m == $past(div_eff(m_q[0])))
        else $error("memory not on programmed dividers");

    div_nonzero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pixel_m != 7'h00 && pixel_n != 7'h00 && memory_m != 7'h00 && memory_n != 7'h00)
        else $error("divider value zero reached output");

    force_high_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        clk_en ##1 clk_en |-> pixel_force_high == (!pixel_vco_en && pixel_out_en))
        else $error("forced-high output inconsistent");

endmodule : clkgen_select_prog

// *** rtl/clkgen_consts.svh ***
// Purpose: offsets, field positions, reset values and preset tables of the clock select block
// Assumes: 32-bit register words on AXI4-Lite, byte addresses below
// Notes:   preset words pack {m[6:0], n[6:0], post code[1:0]}
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_REF_HZ        12'h000
`define OFS_PIXEL_STATUS  12'h004
`define OFS_MEMORY_STATUS 12'h008
`define OFS_PIXEL_FREQ    12'h00C
`define OFS_MEMORY_FREQ   12'h010
`define OFS_SERIAL_STATUS 12'h014

// ****************************************************************
// reset values
// ****************************************************************
`define RST_REF_HZ        32'h00DA_7A64
`define RST_DIV           7'h00
`define RST_POST          2'h0

// ****************************************************************
// serial word fields
// ****************************************************************
`define SW_ADDR_BIT       0
`define SW_TRISTATE_BIT   1
`define SW_VCO_OFF_BIT    2
`define SW_MODE_BIT       3
`define SW_POST_LSB       4
`define SW_N_LSB          6
`define SW_M_LSB          13
`define SW_LAST_BIT       5'h13
`define PROG_SELECT_CODE  3'h2

// ****************************************************************
// mask presets, 14.31818 MHz reference
// ****************************************************************
`define PIX_PRESET_0      16'h43D1
`define PIX_PRESET_1      16'h2D5D
`define PIX_PRESET_2      16'h237D
`define PIX_PRESET_3      16'h35D8
`define PIX_PRESET_4      16'h2F40
`define PIX_PRESET_5      16'h1715
`define PIX_PRESET_6      16'h2D58
`define PIX_PRESET_7      16'h237C
`define MEM_PRESET        16'h2298

`endif

// *** rtl/clkgen_pkg.sv ***
// Purpose: types shared by the clock select block and its bench
// Assumes: generator index 1 is the pixel generator, 0 the memory generator
// Notes:   numbers live in clkgen_consts.svh
package clkgen_pkg;

    typedef logic [6:0]  div_type;
    typedef logic [1:0]  post_code_type;
    typedef logic [3:0]  post_val_type;
    typedef logic [2:0]  freq_sel_type;
    typedef logic [4:0]  bit_ptr_type;
    typedef logic [19:0] prog_word_type;

    typedef enum logic [0:0] {
        SRC_PRESET = 1'b0,
        SRC_PROG   = 1'b1
    } div_source_type;

endpackage : clkgen_pkg

// *** verification/sel_ctrl_model.sv ***
// Purpose: display controller model driving the select pins
// Assumes: one serial bit every 160 ns, pins asynchronous to clk_sys
// Notes:   latch_ptr_reset is left high after a word so the latch keeps its code
`timescale 1ns/1ps
module sel_ctrl_model (
    // select and serial pins
    output logic select0_data,
    output logic select1_strobe,
    output logic select2,
    output logic latch_ptr_reset
);
    // ****************
    // pin tasks
    // ****************
    // low through reset
    initial pins(3'h0, 1'b0);
    task automatic pins(input logic [2:0] c, input logic lpr);
        {select2, select1_strobe, select0_data} <= c;
        latch_ptr_reset <= lpr;
        #160;
    endtask : pins
    task automatic send(input logic [2:0] c, input logic [19:0] w, input int nb);
        pins(c, 1'b0);
        latch_ptr_reset <= 1'b1;
        #80;
        for (int i = 0; i < nb; i++) begin
            {select1_strobe, select0_data} <= {1'b0, w[i]};
            #80;
            select1_strobe <= 1'b1;
            #80;
        end
        #80;
    endtask : send
endmodule : sel_ctrl_model

// *** verification/clkgen_select_prog_test.sv ***
// Purpose: self-checking bench of the clock select block
// Assumes: clk_en tied high, full write strobes
// Notes:   expected dividers are unpacked from the mask preset words
`timescale 1ns/1ps
`include "clkgen_consts.svh"
module clkgen_select_prog_test;
    import clkgen_pkg::*;
    localparam logic [15:0] PRE [8] = '{`PIX_PRESET_0, `PIX_PRESET_1, `PIX_PRESET_2,
        `PIX_PRESET_3, `PIX_PRESET_4, `PIX_PRESET_5, `PIX_PRESET_6, `PIX_PRESET_7};
    logic clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1;
    logic select0_data, select1_strobe, select2, latch_ptr_reset;
    div_type pixel_m, pixel_n, memory_m, memory_n;
    post_val_type pixel_p, memory_p;
    logic pixel_programmed, pixel_out_en, pixel_vco_en, pixel_force_high;
    logic memory_programmed, memory_out_en, memory_vco_en, memory_force_high;
    logic [31:0] pixel_freq_hz, memory_freq_hz, s_axi_rdata, rd;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int fail_count = 0, n_checks = 0;
    clkgen_select_prog clkgen_select_prog_i (.*);
    sel_ctrl_model sel_ctrl_model_i (.*);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // ****************
    // axi4-lite access, readies read mid-cycle since they are combinational
    // ****************
    task automatic ax(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic [4:0] t;
        if (wr) begin
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        for (int k = 0; k < 64; k++) begin
            @(negedge clk_sys);
            t = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid};
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge clk_sys);
            if (t[4]) s_axi_awvalid <= 1'b0;
            if (t[3]) s_axi_wvalid <= 1'b0;
            if (t[2]) s_axi_arvalid <= 1'b0;
            if (wr ? t[1] : t[0]) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                // idle edge: the next call must not re-raise a ready in this step
                @(posedge clk_sys);
                return;
            end
        end
        fail_count++;
        print_verdict();
    endtask : ax
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (int c = 0; c < 8; c++) begin
            sel_ctrl_model_i.pins(3'(c), 1'b0);
            chk(32'({pixel_programmed, pixel_m, pixel_n, pixel_p}), 32'({1'b0, PRE[c][15:2], 4'(1) << PRE[c][1:0]}));
        end
        chk(32'({memory_programmed, memory_m, memory_n}), 32'(`MEM_PRESET >> 2));
        $display("test presets done");
        @(posedge clk_sys);
        ax(1'b0, `OFS_REF_HZ, 32'h0000_0000);
        chk(rd, `RST_REF_HZ);
        ax(1'b1, `OFS_REF_HZ, 32'h0100_0000);
        ax(1'b0, `OFS_REF_HZ, 32'h0000_0000);
        chk(rd, 32'h0100_0000);
        ax(1'b0, 12'h100, 32'h0000_0000);
        chk({30'h0, rs}, 32'h0000_0002);
        repeat (4) @(posedge clk_sys);
        chk(pixel_freq_hz, 32'((64'h0100_0000 * PRE[7][8:2]) / PRE[7][15:9]));
        $display("test register bus done");
        sel_ctrl_model_i.send(3'h2, {7'h03, 7'h05, 2'h2, 4'h3}, 20);
        chk(32'({pixel_programmed, pixel_out_en, pixel_vco_en, pixel_force_high, pixel_m, pixel_n, pixel_p}), 32'({4'hA, 7'h03, 7'h05, 4'h4}));
        chk(32'({memory_programmed, memory_m, memory_n}), 32'(`MEM_PRESET >> 2));
        @(posedge clk_sys);
        ax(1'b0, `OFS_SERIAL_STATUS, 32'h0000_0000);
        chk(32'(rd[8:0]), 32'h0000_0140);
        sel_ctrl_model_i.pins(3'h6, 1'b1);
        chk(32'(pixel_programmed), 32'h0000_0001);
        sel_ctrl_model_i.pins(3'h2, 1'b0);
        chk(32'({pixel_programmed, pixel_m}), 32'({1'b0, PRE[2][15:9]}));
        $display("test pixel program done");
        sel_ctrl_model_i.send(3'h5, 20'h0_00FF, 7);
        sel_ctrl_model_i.send(3'h5, {7'h02, 7'h00, 2'h3, 4'h4}, 20);
        chk(32'({memory_programmed, memory_vco_en, memory_force_high, memory_out_en, memory_m, memory_n, memory_p}), 32'({4'hB, 7'h02, 7'h01, 4'h8}));
        chk(memory_freq_hz, 32'h0010_0000);
        chk(32'({pixel_programmed, pixel_out_en, pixel_m}), 32'({2'h0, PRE[5][15:9]}));
        $display("test memory program done");
        print_verdict();
    end
endmodule : clkgen_select_prog_test
